// >>> design/lics_oneshot.sv
`timescale 1ns/1ns
`include "lics_params.svh"
module lics_oneshot #(
   parameter int unsigned CYCLES = `LICS_ONESHOT_CYCLES
) (
   input wire logic clk_in,       // System clock
   input wire logic rst_n_in,     // Synchronous reset
   lics_ring_if.timer ring_if     // Start and active
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic active_q;
   logic active_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // ----------------------------------------
   // Non-retriggerable one-shot
   // ----------------------------------------
   // Crossings during the pulse are ignored so the width stays fixed
   assign active_d = active_q ? (cnt_q != LAST) : ring_if.start; // [R14] [R16]
   assign cnt_d = (active_q && cnt_q != LAST) ? cnt_q + CW'(1) : '0;
   assign ring_if.active = active_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         active_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         active_q <= active_d;
         cnt_q <= cnt_d;
      end
   end

   property p_os_start;
      @(posedge clk_in) disable iff (!rst_n_in)
         (ring_if.start && !active_q) |=> active_q;
   endproperty
   a_os_start: assert property (p_os_start) else $error("one-shot did not start"); // [R14]

   property p_os_end;
      @(posedge clk_in) disable iff (!rst_n_in)
         (active_q && cnt_q == LAST) |=> !active_q;
   endproperty
   a_os_end: assert property (p_os_end) else $error("one-shot did not time out"); // [R16]
endmodule : lics_oneshot

// >>> design/lics_params.svh
`ifndef LICS_PARAMS_SVH
`define LICS_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define LICS_IDX_CTRL2 8'h11
`define LICS_IDX_CTRL3 8'h12
`define LICS_IDX_ISTAT 8'h13
`define LICS_IDX_IMASK 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LICS_B_CAL_CLEAR 7
`define LICS_B_MANUAL_CALIBRATION_START 6
`define LICS_B_CAL_DIS 5
`define LICS_B_OPE 3
`define LICS_B_BTE 2
`define LICS_B_ROV 1
`define LICS_B_BTD 0
`define LICS_B_RING_RECTIFIER_SELECT 1
`define LICS_B_EV_TONE 0
`define LICS_B_EV_OVL 1

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define LICS_RST_CTRL2 8'h00
`define LICS_RST_CTRL3 8'h00
`define LICS_RST_IRQ 2'h0
`define LICS_RESP_OKAY 2'h0
`define LICS_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LICS_CLK_PERIOD_NS 50
`define LICS_ONESHOT_TIME_NS 1000000
`define LICS_ONESHOT_CYCLES (`LICS_ONESHOT_TIME_NS / `LICS_CLK_PERIOD_NS)

`endif

// >>> design/lics_pkg.sv
package lics_pkg;
   typedef enum logic [2:0] {
      LICS_SEL_CTRL2,
      LICS_SEL_CTRL3,
      LICS_SEL_ISTAT,
      LICS_SEL_IMASK,
      LICS_SEL_NONE
   } lics_sel_type;
endpackage : lics_pkg

// >>> design/lics_ring_if.sv
`timescale 1ns/1ns
interface lics_ring_if;
   logic start;
   logic active;
   modport timer (input start, output active);
   modport ctrl (output start, input active);
endinterface : lics_ring_if

// >>> design/lics_top.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lics_params.svh"
// Contract
// R1 - While calibration_clear is 1 the stored receive ADC calibration is discarded.
// R2 - Software writes calibration_clear back to 0 after setting it.
// R3 - Writing 1 to manual_calibration_start starts a manual receive ADC calibration.
// R4 - auto_calibration_disable at 1 suppresses automatic calibration, at 0 allows it.
// R5 - Reserved bits carry no meaning and software must not rely on them.
// R6 - Software clears overload_protection_enable before going off-hook; 1 enables it.
// R7 - While billing_tone_enable is 1 tones are detected and off-hook is held through them.
// R8 - A tone detected while enabled sets the read-only billing_tone_detected flag.
// R9 - Writing 0 to billing_tone_enable also clears billing_tone_detected.
// R10 - While billing_tone_enable is 0 billing_tone_detected is never set.
// R11 - A receive pin below ground sets receive_overload_flag.
// R12 - Writing 0 to receive_overload_flag clears it and receive_overload_irq_flag.
// R13 - With validation off, ring_rectifier_select picks half or full wave detection.
// R14 - With validation on, it picks the validated envelope or a threshold one-shot.
// R15 - Select 0 means half wave or envelope, 1 means full wave or one-shot.
// R16 - The one-shot length is a programmable counter constant.
module lics_top
   import lics_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int unsigned ONESHOT_CYCLES = `LICS_ONESHOT_CYCLES
) (
   input wire logic clk_in,                         // 20 MHz clock
   input wire logic rst_n_in,                       // Synchronous reset
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,   // Write address
   input wire logic s_axi_awvalid_in,               // Write address valid
   output logic s_axi_awready_out,                  // Write address ready
   input wire logic [31:0] s_axi_wdata_in,          // Write data
   input wire logic [3:0] s_axi_wstrb_in,           // Write strobes
   input wire logic s_axi_wvalid_in,                // Write data valid
   output logic s_axi_wready_out,                   // Write data ready
   output logic [1:0] s_axi_bresp_out,              // Write response
   output logic s_axi_bvalid_out,                   // Write response valid
   input wire logic s_axi_bready_in,                // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,   // Read address
   input wire logic s_axi_arvalid_in,               // Read address valid
   output logic s_axi_arready_out,                  // Read address ready
   output logic [31:0] s_axi_rdata_out,             // Read data
   output logic [1:0] s_axi_rresp_out,              // Read response
   output logic s_axi_rvalid_out,                   // Read valid
   input wire logic s_axi_rready_in,                // Read ready
   input wire logic billing_tone_in,                // Tone detector, async
   input wire logic rx_below_ground_in,             // Receive overload, async
   input wire logic ring_raw_in,                    // Ring detector output, async
   input wire logic ring_threshold_in,              // Ring threshold comparator, async
   input wire logic ring_validated_in,              // Validated envelope, async
   input wire logic ring_validation_enable_in,      // Validation on, same clock
   output logic calibration_clear_out,              // Discard calibration
   output logic manual_calibration_start_out,       // One-cycle start pulse
   output logic auto_calibration_disable_out,       // Suppress auto calibration
   output logic overload_protection_enable_out,     // Overload protection on
   output logic billing_tone_enable_out,            // Tone detection on
   output logic offhook_hold_out,                   // Hold off-hook during tone
   output logic ring_fullwave_out,                  // Detector rectifier mode
   output logic ring_detect_output_out,             // Ring detect pin level
   output logic irq_out                             // Level interrupt
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic lics_sel_type reg_dec(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] base;
      base = a >> 2;
      if (a[1:0] != 2'h0) return LICS_SEL_NONE;
      if (base == ADDR_W'(`LICS_IDX_CTRL2)) return LICS_SEL_CTRL2;
      if (base == ADDR_W'(`LICS_IDX_CTRL3)) return LICS_SEL_CTRL3;
      if (base == ADDR_W'(`LICS_IDX_ISTAT)) return LICS_SEL_ISTAT;
      if (base == ADDR_W'(`LICS_IDX_IMASK)) return LICS_SEL_IMASK;
      return LICS_SEL_NONE;
   endfunction : reg_dec

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic thr_prev_q;
   wire [4:0] async_in = {ring_validated_in, ring_threshold_in, ring_raw_in,
                          rx_below_ground_in, billing_tone_in};
   wire tone_s = sync2_q[0];
   wire ovl_s = sync2_q[1];
   wire ring_raw_s = sync2_q[2];
   wire thr_s = sync2_q[3];
   wire valid_s = sync2_q[4];

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         thr_prev_q <= 1'b0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
         thr_prev_q <= thr_s;
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   assign s_axi_awready_out = !aw_held_q && !bvalid_q;
   assign s_axi_wready_out = !w_held_q && !bvalid_q;
   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire [ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr_in;
   wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata_in;
   wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb_in;
   wire wr_fire = (aw_held_q || aw_take) && (w_held_q || w_take);
   wire lics_sel_type wr_sel = reg_dec(wr_addr);
   // Registers are 8 bits wide; only lane 0 writes
   wire wr_lane = wr_fire && wr_strb[0];
   wire [7:0] wd = wr_data[7:0];
   wire wr_c2 = wr_lane && wr_sel == LICS_SEL_CTRL2;
   wire wr_c3 = wr_lane && wr_sel == LICS_SEL_CTRL3;
   wire wr_is = wr_lane && wr_sel == LICS_SEL_ISTAT;
   wire wr_im = wr_lane && wr_sel == LICS_SEL_IMASK;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `LICS_RESP_OKAY;
      end else begin
         aw_held_q <= (aw_held_q || aw_take) && !wr_fire;
         w_held_q <= (w_held_q || w_take) && !wr_fire;
         if (aw_take) aw_addr_q <= s_axi_awaddr_in;
         if (w_take) w_data_q <= s_axi_wdata_in;
         if (w_take) w_strb_q <= s_axi_wstrb_in;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == LICS_SEL_NONE) ? `LICS_RESP_SLVERR : `LICS_RESP_OKAY;
         end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   logic cal_clr_q, manual_calibration_start_q, cal_dis_q, ope_q, bte_q, rov_q, btd_q, ring_rectifier_select_q;
   logic manual_calibration_start_pulse_q;
   logic [1:0] istat_q;
   logic [1:0] imask_q;

   wire rov_clr = wr_c2 && !wd[`LICS_B_ROV];
   wire bte_clr = wr_c2 && !wd[`LICS_B_BTE];
   wire tone_set = bte_q && tone_s; // [R8] [R10]
   // Overload set wins over a clearing write
   wire rov_d = ovl_s || (rov_q && !rov_clr); // [R11] [R12]
   // Disabling tone detection clears the flag even against a tone
   wire btd_d = !bte_clr && (tone_set || btd_q); // [R9] [R10]
   wire [1:0] ev_set = {ovl_s, tone_set};
   wire [1:0] ev_clr = (wr_is ? wd[1:0] : 2'h0) | {rov_clr, 1'b0}; // [R12]
   wire [1:0] istat_d = (istat_q & ~ev_clr) | ev_set;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         {cal_clr_q, manual_calibration_start_q, cal_dis_q} <= 3'(`LICS_RST_CTRL2 >> `LICS_B_CAL_DIS);
         {ope_q, bte_q} <= 2'(`LICS_RST_CTRL2 >> `LICS_B_BTE);
         {rov_q, btd_q} <= 2'(`LICS_RST_CTRL2);
         ring_rectifier_select_q <= 1'(`LICS_RST_CTRL3 >> `LICS_B_RING_RECTIFIER_SELECT);
         manual_calibration_start_pulse_q <= 1'b0;
         istat_q <= `LICS_RST_IRQ;
         imask_q <= `LICS_RST_IRQ;
      end else begin
         if (wr_c2) begin
            cal_clr_q <= wd[`LICS_B_CAL_CLEAR]; // [R1]
            manual_calibration_start_q <= wd[`LICS_B_MANUAL_CALIBRATION_START];
            cal_dis_q <= wd[`LICS_B_CAL_DIS]; // [R4]
            ope_q <= wd[`LICS_B_OPE];
            bte_q <= wd[`LICS_B_BTE]; // [R7]
         end
         manual_calibration_start_pulse_q <= wr_c2 && wd[`LICS_B_MANUAL_CALIBRATION_START]; // [R3]
         if (wr_c3) ring_rectifier_select_q <= wd[`LICS_B_RING_RECTIFIER_SELECT];
         if (wr_im) imask_q <= wd[1:0];
         rov_q <= rov_d;
         btd_q <= btd_d;
         istat_q <= istat_d;
      end
   end

   // ----------------------------------------
   // Ring detect routing
   // ----------------------------------------
   lics_ring_if ring_if ();
   assign ring_if.start = ring_validation_enable_in && thr_s && !thr_prev_q;
   lics_oneshot #(.CYCLES(ONESHOT_CYCLES)) u_oneshot (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ring_if(ring_if)
   );
   // 0 = envelope, 1 = one-shot; the raw detector carries its own mode
   wire ring_d = !ring_validation_enable_in ? ring_raw_s : // [R13]
                 (ring_rectifier_select_q ? ring_if.active : valid_s);       // [R14] [R15]

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic ring_q, hold_q, irq_q;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ring_q <= 1'b0;
         hold_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         ring_q <= ring_d;
         hold_q <= bte_q && tone_s; // [R7]
         irq_q <= |(istat_d & imask_q);
      end
   end
   assign calibration_clear_out = cal_clr_q;
   assign manual_calibration_start_out = manual_calibration_start_pulse_q;
   assign auto_calibration_disable_out = cal_dis_q;
   assign overload_protection_enable_out = ope_q;
   assign billing_tone_enable_out = bte_q;
   assign offhook_hold_out = hold_q;
   assign ring_fullwave_out = ring_rectifier_select_q; // [R13] [R15]
   assign ring_detect_output_out = ring_q;
   assign irq_out = irq_q;

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   logic rvalid_q;
   logic [7:0] rdata_q;
   logic [1:0] rresp_q;
   wire lics_sel_type rd_sel = reg_dec(s_axi_araddr_in);
   // Reserved bits read as zero
   wire [7:0] ctrl2_val = {cal_clr_q, manual_calibration_start_q, cal_dis_q, 1'b0,
                           ope_q, bte_q, rov_q, btd_q}; // [R5]
   wire [7:0] ctrl3_val = {6'h00, ring_rectifier_select_q, 1'b0}; // [R5]
   wire [7:0] rd_val = (rd_sel == LICS_SEL_CTRL2) ? ctrl2_val :
                       (rd_sel == LICS_SEL_CTRL3) ? ctrl3_val :
                       (rd_sel == LICS_SEL_ISTAT) ? {6'h00, istat_q} :
                       (rd_sel == LICS_SEL_IMASK) ? {6'h00, imask_q} : 8'h00;
   assign s_axi_arready_out = !rvalid_q;
   wire ar_take = s_axi_arvalid_in && s_axi_arready_out;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 8'h00;
         rresp_q <= `LICS_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
         rresp_q <= (rd_sel == LICS_SEL_NONE) ? `LICS_RESP_SLVERR : `LICS_RESP_OKAY;
      end else if (s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = {24'h000000, rdata_q};
   assign s_axi_rresp_out = rresp_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_calclr;
      @(posedge clk_in) disable iff (!rst_n_in)
         (wr_c2 && wd[`LICS_B_CAL_CLEAR]) |=> calibration_clear_out;
   endproperty
   a_calclr: assert property (p_calclr) else $error("calibration clear not held"); // [R1]
   property p_manual_calibration_start;
      @(posedge clk_in) disable iff (!rst_n_in)
         (wr_c2 && wd[`LICS_B_MANUAL_CALIBRATION_START]) |=> manual_calibration_start_out ##1
            (!manual_calibration_start_out || $past(wr_c2 && wd[`LICS_B_MANUAL_CALIBRATION_START]));
   endproperty
   a_manual_calibration_start: assert property (p_manual_calibration_start) else $error("manual calibration pulse wrong"); // [R3]
   property p_caldis;
      @(posedge clk_in) disable iff (!rst_n_in)
         wr_c2 |=> auto_calibration_disable_out == $past(wd[`LICS_B_CAL_DIS]);
   endproperty
   a_caldis: assert property (p_caldis) else $error("auto calibration disable wrong"); // [R4]
   property p_rsvd;
      @(posedge clk_in) disable iff (!rst_n_in)
         (ar_take && rd_sel == LICS_SEL_CTRL3) |=> s_axi_rdata_out[7:2] == 6'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // [R5]
   property p_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
         (!bte_q || !tone_s) |=> !offhook_hold_out;
   endproperty
   a_hold: assert property (p_hold) else $error("off-hook held while disabled"); // [R7]
   property p_btd_set;
      @(posedge clk_in) disable iff (!rst_n_in)
         (bte_q && tone_s && !bte_clr) |=> btd_q ##0 istat_q[`LICS_B_EV_TONE];
   endproperty
   a_btd_set: assert property (p_btd_set) else $error("tone flag not set"); // [R8]
   property p_btd_clr;
      @(posedge clk_in) disable iff (!rst_n_in)
         bte_clr |=> !btd_q;
   endproperty
   a_btd_clr: assert property (p_btd_clr) else $error("tone flag not cleared"); // [R9]
   property p_btd_off;
      @(posedge clk_in) disable iff (!rst_n_in)
         (!bte_q && !btd_q) |=> !btd_q;
   endproperty
   a_btd_off: assert property (p_btd_off) else $error("tone flag set while disabled"); // [R10]
   property p_rov_set;
      @(posedge clk_in) disable iff (!rst_n_in)
         ovl_s |=> rov_q && istat_q[`LICS_B_EV_OVL];
   endproperty
   a_rov_set: assert property (p_rov_set) else $error("overload flag not set"); // [R11]

   property p_rov_clr;
      @(posedge clk_in) disable iff (!rst_n_in)
         (rov_clr && !ovl_s) |=> !rov_q && !istat_q[`LICS_B_EV_OVL];
   endproperty
   a_rov_clr: assert property (p_rov_clr) else $error("overload flags not cleared"); // [R12]

   property p_ring;
      @(posedge clk_in) disable iff (!rst_n_in)
         1'b1 |=> ring_detect_output_out == ($past(ring_validation_enable_in) ?
            ($past(ring_rectifier_select_q) ? $past(ring_if.active) : $past(valid_s)) : $past(ring_raw_s));
   endproperty
   a_ring: assert property (p_ring) else $error("ring detect routing wrong"); // [R13]
endmodule : lics_top

// >>> sim/lics_top_bench.sv
`timescale 1ns/1ns
`include "lics_params.svh"
module lics_top_bench;
   localparam int OS_LEN = 8;
   localparam int LIMIT = 5000;
   localparam logic [11:0] A_C2 = {2'h0, `LICS_IDX_CTRL2, 2'h0};
   localparam logic [11:0] A_C3 = {2'h0, `LICS_IDX_CTRL3, 2'h0};
   localparam logic [11:0] A_ST = {2'h0, `LICS_IDX_ISTAT, 2'h0};
   localparam logic [11:0] A_MK = {2'h0, `LICS_IDX_IMASK, 2'h0};
   logic clk_in, rst_n_in;
   logic [11:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic tone, ovl, raw, thr, vld, ven;
   logic cal_clr, manual_calibration_start, cal_dis, overload_protection_enable, billing_tone_enable, hold, fullw, rdet, irq;
   int fail_count, total_checks, cycles, pulses, p0, n;
   int bits[4] = '{7, 5, 3, 2};

   lics_top #(.ADDR_W(12), .ONESHOT_CYCLES(OS_LEN)) u_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .billing_tone_in(tone), .rx_below_ground_in(ovl), .ring_raw_in(raw),
      .ring_threshold_in(thr), .ring_validated_in(vld), .ring_validation_enable_in(ven),
      .calibration_clear_out(cal_clr), .manual_calibration_start_out(manual_calibration_start),
      .auto_calibration_disable_out(cal_dis), .overload_protection_enable_out(overload_protection_enable),
      .billing_tone_enable_out(billing_tone_enable), .offhook_hold_out(hold), .ring_fullwave_out(fullw),
      .ring_detect_output_out(rdet), .irq_out(irq)
   );

   // ----------------------------------------
   // Clock, pulse monitor and watchdog
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Start strobe lasts one cycle, so count it at every edge
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (manual_calibration_start === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == LIMIT) begin
         fail_count++;
         $display("unexpected at %0t: watchdog expired", $time);
         close_out();
      end
   end

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task idle(input int k);
      repeat (k) @(posedge clk_in);
   endtask : idle

   task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_in);
         if (!aw_ok && awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_in); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rdr

   task expect_reg(input logic [11:0] a, input logic [31:0] exp);
      rdr(a, rd, rs);
      check(rs, `LICS_RESP_OKAY, "read response");
      check(rd, exp, "register value");
   endtask : expect_reg

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {tone, ovl, raw, thr, vld, ven} = '0;
      {fail_count, total_checks, cycles, pulses} = '0;
      rst_n_in = 1'b0;
      idle(2);
      rst_n_in <= 1'b1;
      expect_reg(A_C2, 32'h00);
      expect_reg(A_C3, 32'h00);
      expect_reg(A_ST, 32'h00);
      expect_reg(A_MK, 32'h00);
      check({cal_clr, cal_dis, overload_protection_enable, billing_tone_enable, hold, fullw, rdet, irq}, 32'h00, "reset outputs");
      $display("test reset done");
      // Ones to RO and reserved places must not stick
      p0 = pulses;
      wr(A_C2, 32'hFF, rs);
      idle(2);
      check(pulses - p0, 32'h1, "start pulse count");
      check({cal_clr, cal_dis, overload_protection_enable, billing_tone_enable}, 32'hF, "ctrl2 outputs set");
      expect_reg(A_C2, 32'hEC);
      wr(A_C2, 32'h00, rs);
      idle(2);
      check({cal_clr, cal_dis, overload_protection_enable, billing_tone_enable}, 32'h0, "ctrl2 outputs clear");
      check(pulses - p0, 32'h1, "no start on zero");
      foreach (bits[i]) begin
         wr(A_C2, 32'h1 << bits[i], rs);
         idle(2);
         check({cal_clr, cal_dis, overload_protection_enable, billing_tone_enable}, 32'h8 >> i, "ctrl2 field");
      end
      $display("test control done");
      wr(A_C2, 32'h04, rs);
      tone <= 1'b1;
      idle(6);
      check(hold, 1'b1, "offhook hold");
      check(irq, 1'b0, "masked tone irq");
      tone <= 1'b0;
      idle(5);
      check(hold, 1'b0, "hold released");
      expect_reg(A_C2, 32'h05);
      expect_reg(A_ST, 32'h01);
      wr(A_MK, 32'h01, rs);
      idle(3);
      check(irq, 1'b1, "tone irq");
      wr(A_ST, 32'h01, rs);
      idle(3);
      check(irq, 1'b0, "tone irq cleared");
      expect_reg(A_ST, 32'h00);
      wr(A_C2, 32'h00, rs);
      expect_reg(A_C2, 32'h00);
      tone <= 1'b1;
      idle(6);
      expect_reg(A_C2, 32'h00);
      expect_reg(A_ST, 32'h00);
      check(hold, 1'b0, "no hold when off");
      tone <= 1'b0;
      $display("test billing tone done");
      wr(A_MK, 32'h02, rs);
      ovl <= 1'b1;
      idle(6);
      ovl <= 1'b0;
      idle(4);
      expect_reg(A_C2, 32'h02);
      expect_reg(A_ST, 32'h02);
      check(irq, 1'b1, "overload irq");
      wr(A_C2, 32'h00, rs);
      idle(3);
      expect_reg(A_C2, 32'h00);
      expect_reg(A_ST, 32'h00);
      check(irq, 1'b0, "overload irq cleared");
      $display("test overload done");
      wr(A_C3, 32'h00, rs);
      raw <= 1'b1;
      idle(5);
      check({fullw, rdet}, 32'h1, "half wave ring");
      raw <= 1'b0;
      idle(5);
      check(rdet, 1'b0, "ring idle");
      wr(A_C3, 32'h02, rs);
      idle(2);
      check(fullw, 1'b1, "full wave select");
      expect_reg(A_C3, 32'h02);
      ven <= 1'b1;
      wr(A_C3, 32'h00, rs);
      vld <= 1'b1;
      idle(5);
      check(rdet, 1'b1, "validated envelope");
      vld <= 1'b0;
      idle(5);
      check(rdet, 1'b0, "envelope gone");
      wr(A_C3, 32'h02, rs);
      thr <= 1'b1;
      n = 0;
      repeat (30) begin
         @(posedge clk_in);
         if (rdet === 1'b1) n++;
      end
      check(n, OS_LEN, "one-shot length");
      thr <= 1'b0;
      $display("test ring done");
      rdr(12'h040, rd, rs);
      check(rs, `LICS_RESP_SLVERR, "unmapped read");
      check(rd, 32'h0, "unmapped read data");
      rdr(12'h045, rd, rs);
      check(rs, `LICS_RESP_SLVERR, "misaligned read");
      wr(12'h040, 32'hFF, rs);
      check(rs, `LICS_RESP_SLVERR, "unmapped write");
      wstrb <= 4'hE;
      wr(A_C3, 32'h00, rs);
      check(rs, `LICS_RESP_OKAY, "write without lane 0");
      expect_reg(A_C3, 32'h02);
      $display("test decode done");
      close_out();
   end
endmodule : lics_top_bench
